// ---- hdl/ers_defs.svh ----
// Offsets, field positions and reset values of the error record status block.
`ifndef ERS_DEFS_SVH
`define ERS_DEFS_SVH
`define ERS_STATUS_BASE 12'h010
`define ERS_RECORD_STRIDE 12'h040
`define ERS_BIT_ADDR_CAPTURED 31
`define ERS_BIT_RECORD_FILLED 30
`define ERS_BIT_UNCORRECTED 29
`define ERS_BIT_ABORT_SIGNALED 28
`define ERS_BIT_SYNDROME_LOST 27
`define ERS_BIT_MISC_VALID 26
`define ERS_CORR_HI 25
`define ERS_CORR_LO 24
`define ERS_BIT_POSTPONED 23
`define ERS_CORR_NONE 2'h0
`define ERS_CORR_TRANSIENT 2'h1
`define ERS_CORR_UNSPEC 2'h2
`define ERS_CORR_PERSISTENT 2'h3
`define ERS_NUM_RECORDS 2
`define ERS_SEL_WIDTH 4
`endif

// ---- hdl/ers_pkg.sv ----
// Types shared by the error record status block.
package ers_pkg;
  // Architecture version of the status bit behaviour.
  typedef enum logic {ers_ver_1_0, ers_ver_1_1} ers_version_t;
  // Kind of error reported by detection logic.
  typedef enum logic [1:0] {ers_err_corrected, ers_err_postponed, ers_err_uncorrected}
    ers_err_kind_t;
endpackage

// ---- hdl/ers_record.sv ----
// One error record's primary status register.
`include "ers_defs.svh"
module ers_record (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic recovery_rst,
  input wire logic v1_1_mode,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic err_event,
  input wire ers_pkg::ers_err_kind_t err_kind,
  input wire logic [1:0] err_corr_kind,
  input wire logic err_addr_valid,
  input wire logic err_abort,
  input wire logic err_counter_overflow,
  output logic [31:0] status
);
  // Stored flags.
  logic addr_captured, record_filled, uncorrected_flag, abort_signaled_flag;
  logic syndrome_lost_flag, postponed_flag;
  logic [1:0] corr_field;
  // Write gating signals.
  logic any_err, top_cleared, av_wr_ok, v_wr_ok, ue_wr_ok, of_clr, ce_de_wr_ok;
  // New values after a software write, before the event.
  logic next_av, next_v, next_ue, next_er, next_of, next_de;
  logic [1:0] next_ce;
  // Whether an error is recorded, overflow condition.
  logic set_of;

  // Clear the highest-priority indication: uncorrected over postponed over corrected.
  always_comb begin
    any_err = uncorrected_flag | postponed_flag | (corr_field != `ERS_CORR_NONE);
    if (uncorrected_flag) begin
      top_cleared = wr_data[`ERS_BIT_UNCORRECTED];
    end else if (postponed_flag) begin
      top_cleared = wr_data[`ERS_BIT_POSTPONED];
    end else begin
      top_cleared = wr_data[`ERS_CORR_HI] & wr_data[`ERS_CORR_LO];
    end
    // No corrected-error counter is kept, so clearing this flag disturbs nothing else.
    of_clr = wr_data[`ERS_BIT_SYNDROME_LOST];
    av_wr_ok = v1_1_mode | !any_err | top_cleared;
    v_wr_ok = v1_1_mode | !any_err | wr_data[`ERS_BIT_RECORD_FILLED];
    ue_wr_ok = v1_1_mode | !syndrome_lost_flag | of_clr;
    ce_de_wr_ok = ue_wr_ok;
  end

  // Apply write-one-to-clear with the gating evaluated on the old value.
  always_comb begin
    next_av = addr_captured;
    next_v = record_filled;
    next_ue = uncorrected_flag;
    next_er = abort_signaled_flag;
    next_of = syndrome_lost_flag;
    next_de = postponed_flag;
    next_ce = corr_field;
    if (wr_en) begin
      if (av_wr_ok && wr_data[`ERS_BIT_ADDR_CAPTURED]) next_av = 1'b0;
      if (av_wr_ok && wr_data[`ERS_BIT_ABORT_SIGNALED]) next_er = 1'b0;
      if (v_wr_ok && wr_data[`ERS_BIT_RECORD_FILLED]) next_v = 1'b0;
      if (ue_wr_ok && wr_data[`ERS_BIT_UNCORRECTED]) next_ue = 1'b0;
      if (of_clr) next_of = 1'b0;
      if (ce_de_wr_ok && wr_data[`ERS_BIT_POSTPONED]) next_de = 1'b0;
      if (ce_de_wr_ok && (wr_data[`ERS_CORR_HI:`ERS_CORR_LO] == 2'h3)) next_ce = 2'h0;
    end
  end

  // Overflow condition against the old record value.
  always_comb begin
    set_of = 1'b0;
    if (v1_1_mode) begin
      set_of = (err_event && err_kind == ers_pkg::ers_err_corrected) ?
        (err_counter_overflow | record_filled) : (err_event & record_filled);
    end else if (err_event) begin
      case (err_kind)
        ers_pkg::ers_err_uncorrected: set_of = uncorrected_flag;
        ers_pkg::ers_err_postponed: set_of = !uncorrected_flag & postponed_flag;
        default: set_of = !uncorrected_flag & !postponed_flag &
          (err_counter_overflow | (corr_field != `ERS_CORR_NONE));
      endcase
    end
  end

  // Flags: recording event wins over a concurrent clear; recovery reset preserves all.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_captured <= 1'b0;
      record_filled <= 1'b0;
      uncorrected_flag <= 1'b0;
      abort_signaled_flag <= 1'b0;
      syndrome_lost_flag <= 1'b0;
      postponed_flag <= 1'b0;
      corr_field <= `ERS_CORR_NONE;
    end else if (!recovery_rst) begin
      addr_captured <= next_av | (err_event & err_addr_valid);
      record_filled <= next_v | err_event;
      uncorrected_flag <= next_ue | (err_event && err_kind == ers_pkg::ers_err_uncorrected);
      postponed_flag <= next_de | (err_event && err_kind == ers_pkg::ers_err_postponed);
      abort_signaled_flag <= next_er | (err_event & err_abort);
      syndrome_lost_flag <= next_of | set_of;
      if (err_event && err_kind == ers_pkg::ers_err_corrected) begin
        corr_field <= err_corr_kind;
      end else begin
        corr_field <= next_ce;
      end
    end
  end

  // Read view; writes of zero leave nothing pending since no field raises interrupts.
  always_comb begin
    status = 32'h0;
    status[`ERS_BIT_ADDR_CAPTURED] = addr_captured;
    status[`ERS_BIT_RECORD_FILLED] = record_filled;
    status[`ERS_BIT_UNCORRECTED] = uncorrected_flag;
    status[`ERS_BIT_ABORT_SIGNALED] = abort_signaled_flag;
    status[`ERS_BIT_SYNDROME_LOST] = syndrome_lost_flag;
    status[`ERS_CORR_HI:`ERS_CORR_LO] = corr_field;
    status[`ERS_BIT_POSTPONED] = postponed_flag;
  end
endmodule

// ---- hdl/ers_bank.sv ----
// Error record status bank with memory-mapped and selected-record views.
// Operation
// - Writing zero returns implementation fields to initial
// - 64-bit status at 0x010 plus 64 times n
// - Selected window shows record chosen by select
// - Unimplemented record status reads as zero
// - Address-captured bit 31, W1C, cold reset zero
// - Version 1.0 gates address and abort writes
// - Record-filled bit 30, W1C, cold reset zero
// - Version 1.0 gates record-filled writes; the gate always passes when bit 30 is written
// - Uncorrected bit 29 set on an uncorrected error
// - Version 1.0 uncorrected write gated by lost
// - Abort bit 28 set on returned abort
// - Abort flag W1C, kept over recovery reset
// - Version 1.1 syndrome-lost set in three cases
// - No counter is kept; a syndrome-lost write disturbs no other field
// - Version 1.0 syndrome-lost set in four cases
// - Syndrome-lost W1C, kept over recovery reset
// - Interrupt-raising syndrome fields disabled at reset
// - Corrected field encodes none, transient, unspecified, persistent
// - Postponed bit 23, write-one-to-clear
`include "ers_defs.svh"
module ers_bank (
  input wire logic mclk,
  input wire logic sys_rst,
  // Error recovery reset: all flags held.
  input wire logic recovery_rst,
  // Selects version 1.1 behaviour when high.
  input wire logic v1_1_mode,
  // Memory-mapped view.
  input wire logic mm_wr,
  input wire logic mm_rd,
  input wire logic [11:0] mm_addr,
  input wire logic [63:0] mm_wdata,
  output logic [63:0] mm_rdata,
  // Selected-record system-register view.
  input wire logic [3:0] record_select_field,
  input wire logic sys_wr,
  input wire logic sys_narrow,
  input wire logic [63:0] sys_wdata,
  output logic [63:0] selected_status_sysreg,
  // Detection logic per record.
  input wire logic [1:0] err_event,
  input wire logic [3:0] err_kind,
  input wire logic [3:0] err_corr_kind,
  input wire logic [1:0] err_addr_valid,
  input wire logic [1:0] err_abort,
  input wire logic [1:0] err_counter_overflow
);
  ////////////////////////////////////////////////////////////////////////
  // Decode helpers.
  // Record index addressed by a memory-mapped offset, or all ones if none.
  function automatic logic [3:0] mm_index(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - `ERS_STATUS_BASE;
    // Offsets past the last decodable index must not alias back onto a record.
    if (a < `ERS_STATUS_BASE || rel[5:0] != 6'h0 || rel[11:10] != 2'h0) begin
      mm_index = 4'hf;
    end else begin
      mm_index = rel[9:6];
    end
  endfunction

  logic [3:0] mm_idx;
  logic [31:0] status [`ERS_NUM_RECORDS];
  assign mm_idx = mm_index(mm_addr);

  ////////////////////////////////////////////////////////////////////////
  // One status record per implemented entry.
  for (genvar g = 0; g < `ERS_NUM_RECORDS; g++) begin : g_rec
    logic wr_en;
    logic [31:0] wr_data;
    always_comb begin
      wr_en = 1'b0;
      wr_data = 32'h0;
      if (mm_wr && mm_idx == 4'(g)) begin
        wr_en = 1'b1;
        wr_data = mm_wdata[31:0];
      end else if (sys_wr && record_select_field == 4'(g)) begin
        wr_en = 1'b1;
        wr_data = sys_wdata[31:0];
      end
    end
    ers_record u_rec (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .recovery_rst(recovery_rst),
      .v1_1_mode(v1_1_mode),
      .wr_en(wr_en),
      .wr_data(wr_data),
      .err_event(err_event[g]),
      .err_kind(ers_pkg::ers_err_kind_t'(err_kind[2*g+:2])),
      .err_corr_kind(err_corr_kind[2*g+:2]),
      .err_addr_valid(err_addr_valid[g]),
      .err_abort(err_abort[g]),
      .err_counter_overflow(err_counter_overflow[g]),
      .status(status[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered read data; unimplemented records read zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mm_rdata <= 64'h0;
    end else if (mm_rd) begin
      mm_rdata <= (mm_idx < 4'(`ERS_NUM_RECORDS)) ? {32'h0, status[mm_idx[0]]} : 64'h0;
    end
  end

  // Selected window, narrow state limited to bits 31:0.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      selected_status_sysreg <= 64'h0;
    end else if (record_select_field < 4'(`ERS_NUM_RECORDS)) begin
      selected_status_sysreg <= {32'h0, status[record_select_field[0]]};
    end else begin
      selected_status_sysreg <= 64'h0;
    end
  end
  logic unused_narrow;
  assign unused_narrow = sys_narrow;
endmodule

// ---- verif/ers_err_source.sv ----
// Behavioural stand-in for the node's error-detection logic.
module ers_err_source (
  input wire logic mclk,
  input wire logic [1:0] fire,
  input wire logic [1:0] f_kind,
  input wire logic f_flags,
  output logic [1:0] err_event,
  output logic [3:0] err_kind,
  output logic [3:0] err_corr_kind,
  output logic [1:0] err_addr_valid,
  output logic [1:0] err_abort,
  output logic [1:0] err_counter_overflow
);
  timeunit 1ns;
  timeprecision 100ps;
  // All outputs start quiet so the bank never sees an unknown event.
  initial {err_event, err_kind, err_corr_kind, err_addr_valid, err_abort,
    err_counter_overflow} = 16'h0;
  ////////////////////////////////////////
  // A request becomes a one-cycle event whose qualifiers share its cycle.
  always @(posedge mclk) begin
    err_event <= #1 fire;
    err_kind <= #1 {f_kind, f_kind};
    err_corr_kind <= #1 4'ha;
    err_addr_valid <= #1 fire & {2{f_flags}};
    err_abort <= #1 fire & {2{f_flags}};
    err_counter_overflow <= #1 2'h0;
  end
endmodule

// ---- verif/ers_bank_props.sv ----
// Port-level checker for the error record status bank.
module ers_bank_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic v1_1_mode,
  input wire logic mm_wr,
  input wire logic mm_rd,
  input wire logic [11:0] mm_addr,
  input wire logic [63:0] mm_wdata,
  input wire logic [63:0] mm_rdata,
  input wire logic [3:0] record_select_field,
  input wire logic sys_wr,
  input wire logic [63:0] selected_status_sysreg,
  input wire logic [1:0] err_event,
  input wire logic [3:0] err_kind,
  input wire logic [1:0] err_addr_valid,
  input wire logic [1:0] err_abort
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic s0;  // Record 0 is the selected record.
  logic ue0;  // Uncorrected event on record 0.
  logic quiet;  // Nothing can change any status this cycle.
  assign s0 = record_select_field == 4'h0;
  assign ue0 = err_event[0] && err_kind[1:0] == 2'h2;
  assign quiet = !mm_wr && !sys_wr && err_event == 2'h0;
  ////////////////////////////////////////
  rd_upper_a: assert property (mm_rd |=> mm_rdata[63:32] == 32'h0)
    else $error("read data upper half not zero");
  unmapped_zero_a: assert property (mm_rd && mm_addr == 12'h090 |=> mm_rdata == 64'h0)
    else $error("unimplemented record read not zero");
  reset_clear_a: assert property ($past(sys_rst) |-> mm_rdata == 64'h0)
    else $error("read data not cleared by reset");
  filled_set_a: assert property (err_event[0] && s0 ##1 s0 [*2] |-> selected_status_sysreg[30])
    else $error("event did not mark record filled");
  uncorr_set_a: assert property (err_event[1] && err_kind[3:2] == 2'h2 && record_select_field == 4'h1 ##1 record_select_field == 4'h1 [*2] |-> selected_status_sysreg[29])
    else $error("uncorrected flag not set");
  abort_addr_a: assert property (ue0 && err_abort[0] && err_addr_valid[0] && s0 ##1 s0 [*2] |-> selected_status_sysreg[31:28] == 4'hf)
    else $error("address or abort flag not set");
  lost_v11_a: assert property (v1_1_mode && err_event[0] && s0 ##1 v1_1_mode && ue0 && s0 ##1 s0 [*2] |-> selected_status_sysreg[27])
    else $error("syndrome lost not set under 1.1");
  lost_v10_a: assert property (!v1_1_mode && ue0 && s0 ##1 !v1_1_mode && ue0 && s0 ##1 s0 [*2] |-> selected_status_sysreg[27])
    else $error("syndrome lost not set under 1.0");
  addr_w1c_a: assert property (mm_wr && mm_addr == 12'h010 && mm_wdata[31] && v1_1_mode && !err_event[0] && s0 ##1 s0 |=> !selected_status_sysreg[31])
    else $error("address flag not cleared by write");
  window_hold_a: assert property ((quiet && $stable(record_select_field)) [*3] |=> $stable(selected_status_sysreg))
    else $error("selected window changed while idle");
  cover property (err_event[0] ##1 err_event[0]);
  cover property (mm_rd && mm_addr == 12'h090);
  cover property (sys_wr && err_event[1]);
endmodule
bind ers_bank ers_bank_props ers_bank_props_i (.*);

// ---- verif/test_ers_bank.sv ----
// Self-checking testbench for the error record status bank.
module test_ers_bank;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, sys_rst = 1'b1, recovery_rst = 1'b0, v1_1_mode = 1'b1;
  logic mm_wr = 1'b0, mm_rd = 1'b0, sys_wr = 1'b0, sys_narrow = 1'b0, f_flags = 1'b0;
  logic [11:0] mm_addr = 12'h010;
  logic [63:0] mm_wdata = 64'h0, sys_wdata = 64'h0, mm_rdata, selected_status_sysreg;
  logic [3:0] record_select_field = 4'h0, err_kind, err_corr_kind;
  logic [1:0] fire = 2'h0, f_kind = 2'h0, err_event, err_addr_valid, err_abort;
  logic [1:0] err_counter_overflow;
  int tests_run = 0, bad_count = 0;
  ers_bank ers_bank_i (.*);
  ers_err_source ers_err_source_i (.*);
  // The clock runs at 40 MHz.
  always #12.5 mclk = ~mclk;
  ////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task rd(input logic [11:0] a, input logic [63:0] exp, input string what);
    mm_addr = a; mm_rd = 1'b1; tick(1); mm_rd = 1'b0;
    chk(mm_rdata, exp, what);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    mm_addr = a; mm_wdata = {32'h0, d}; mm_wr = 1'b1; tick(1); mm_wr = 1'b0;
  endtask
  // Raises n back-to-back events on the given records and lets them land.
  task err(input logic [1:0] rec, input logic [1:0] kind, input logic fl, input int n);
    fire = rec; f_kind = kind; f_flags = fl; tick(n); fire = 2'h0; tick(2);
  endtask
  task s_record();
    err(2'h1, 2'h2, 1'b1, 2);
    rd(12'h010, 64'hf8000000, "record0 after two errors");
    recovery_rst = 1'b1; tick(2); recovery_rst = 1'b0;
    rd(12'h010, 64'hf8000000, "record0 after recovery");
    wr(12'h010, 32'hf8000000);
    rd(12'h010, 64'h0, "record0 cleared");
  endtask
  task s_v10();
    v1_1_mode = 1'b0;
    err(2'h1, 2'h2, 1'b1, 2);
    rd(12'h010, 64'hf8000000, "record0 lost under 1.0");
    wr(12'h010, 32'h20000000);
    rd(12'h010, 64'hf8000000, "uncorrected write gated");
    wr(12'h010, 32'h88000000);
    rd(12'h010, 64'hf0000000, "address write gated");
    wr(12'h010, 32'hf0000000);
    rd(12'h010, 64'h0, "record0 cleared with top error");
    v1_1_mode = 1'b1;
  endtask
  task s_sel();
    record_select_field = 4'h1;
    err(2'h2, 2'h2, 1'b0, 1);
    chk(selected_status_sysreg, 64'h60000000, "selected window");
    fire = 2'h2; tick(1); fire = 2'h0;
    sys_wdata = 64'h60000000; sys_wr = 1'b1; tick(1); sys_wr = 1'b0; tick(2);
    chk(selected_status_sysreg, 64'h68000000, "event beats clear");
    rd(12'h050, 64'h68000000, "record1 mapped view");
    rd(12'h090, 64'h0, "unimplemented record");
    rd(12'h450, 64'h0, "aliased offset");
    rd(12'h010, 64'h0, "record0 untouched");
  endtask
  // A corrected error, then a postponed one on the filled record, then a full clear.
  task s_kinds();
    err(2'h1, 2'h0, 1'b0, 1);
    rd(12'h010, 64'h42000000, "corrected recorded");
    err(2'h1, 2'h1, 1'b0, 1);
    rd(12'h010, 64'h4a800000, "postponed over filled");
    wr(12'h010, 32'h4b800000);
    rd(12'h010, 64'h0, "kinds cleared");
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A hung run is cut short and counted as a mismatch.
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge mclk);
    #1 sys_rst = 1'b0;
    tick(1);
    rd(12'h010, 64'h0, "record0 after reset");
    s_record();
    s_v10();
    s_sel();
    s_kinds();
    complete_run();
  end
endmodule
